// *** shared/umd_pkg.sv ***
// Package with the address map, target codes and carrier structs of the memory map decoder.
package umd_pkg;

  // ----------------------------------------------------------------------
  // Address space
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 24;
  localparam int unsigned SEG_W       = 8;
  localparam int unsigned PAGE_W      = 2;
  localparam int unsigned SEG_LSB     = 16;
  localparam int unsigned PAGE_LSB    = 14;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned FLASH_RD_W  = 128;
  localparam int unsigned PRAM_OFS_W  = 12;
  localparam int unsigned SECT_OFS_W  = 12;
  localparam int unsigned SECT_W      = 6;
  localparam int unsigned PROG_BLK_W  = 7;
  localparam int unsigned PROT_SIZE_W = 12;
  localparam int unsigned BIT_IDX_W   = 4;
  localparam int unsigned FL_SECTORS  = 40;

  // ----------------------------------------------------------------------
  // Region bounds (inclusive)
  // ----------------------------------------------------------------------
  localparam logic [23:0] IMB_LO    = 24'hFFFF00;
  localparam logic [23:0] IMB_HI    = 24'hFFFFFF;
  localparam logic [23:0] EPRAM_LO  = 24'hE80000;
  localparam logic [23:0] EPRAM_HI  = 24'hEFFFFF;
  localparam logic [23:0] PRAM_LO   = 24'hE00000;
  localparam logic [23:0] PRAM_HI   = 24'hE7FFFF;
  localparam logic [23:0] FL1_LO    = 24'hC40000;
  localparam logic [23:0] FL1_HI    = 24'hC47FFF;
  localparam logic [23:0] FL0_LO    = 24'hC00000;
  localparam logic [23:0] FL0_HI    = 24'hC20FFF;
  localparam logic [23:0] FL0_CTL_LO = 24'hC0F000;
  localparam logic [23:0] FL0_CTL_HI = 24'hC0FFFF;
  localparam logic [23:0] CAN_LO    = 24'h200000;
  localparam logic [23:0] CAN_HI    = 24'h203FFF;
  localparam logic [23:0] SCU_LO    = 24'h204000;
  localparam logic [23:0] SCU_HI    = 24'h204FFF;
  localparam logic [23:0] CANA_LO   = 24'h208000;
  localparam logic [23:0] CANA_HI   = 24'h20AFFF;
  localparam logic [23:0] SCUA_LO   = 24'h20B000;
  localparam logic [23:0] SCUA_HI   = 24'h20B7FF;
  localparam logic [23:0] SFR_LO    = 24'h00FE00;
  localparam logic [23:0] SFR_HI    = 24'h00FFFF;
  localparam logic [23:0] DPR_LO    = 24'h00F600;
  localparam logic [23:0] DPR_HI    = 24'h00FDFF;
  localparam logic [23:0] DPR_BIT_LO = 24'h00FD00;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_LO   = 24'h00F000;
  localparam logic [23:0] EXTENDED_FUNCTION_REGS_HI   = 24'h00F1FF;
  localparam logic [23:0] EXTRA_FUNCTION_REGS_LO   = 24'h00E000;
  localparam logic [23:0] EXTRA_FUNCTION_REGS_HI   = 24'h00EFFF;
  localparam logic [23:0] DRAM_LO   = 24'h00C800;
  localparam logic [23:0] DRAM_HI   = 24'h00DFFF;
  localparam logic [7:0]  SYS_SEG   = 8'h00;
  localparam logic [23:0] PROT_SIZE_RST = 24'h000000;

  // ----------------------------------------------------------------------
  // Targets and carriers
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    UMD_T_NONE, UMD_T_FLASH0, UMD_T_FLASH1, UMD_T_PRAM, UMD_T_EPRAM,
    UMD_T_DRAM, UMD_T_DUAL_PORT_RAM, UMD_T_SFR, UMD_T_EXTENDED_FUNCTION_REGS, UMD_T_EXTRA_FUNCTION_REGS,
    UMD_T_LPBUS, UMD_T_IMB, UMD_T_EXT
  } umd_target_t;

  typedef enum logic [1:0] {
    UMD_PROT_OFF, UMD_PROT_PARITY, UMD_PROT_ECC
  } umd_prot_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [23:0] addr;
  } umd_req_t;

  typedef struct packed {
    logic        valid;
    umd_target_t target;
    logic        via_sysbus;
    logic        bit_addr;
    logic        fl_ctl;
    logic        wr_block;
    logic [1:0]  page;
    logic [23:0] addr;
  } umd_route_t;

endpackage

// *** rtl/umd_decoder.sv ***
// Unified memory map decoder for the code fetch and data transfer managers.
// Contract
// - Decode 16 Mbyte space: 256 segments of 64 Kbytes, four pages each.
// - Byte and word accesses are accepted at every address.
// - Internal data memories and both register areas decode in segment 0.
// - Instruction fetches route through the code fetch manager only.
// - Data transfers route through the data transfer manager only.
// - System bus links both managers, concurrent traffic both directions.
// - Serial channel and CAN register regions go to the local peripheral bus.
// - Reserved areas become external bus accesses when the bus is present.
// - 4 Kbyte program RAM at E0'0000; programmable protected region rejects writes.
// - 6 Kbyte data RAM at 00'C800 on its own data port.
// - 2 Kbyte dual port RAM holds register banks of 16 words or bytes.
// - Top 256 bytes of dual port RAM and register locations are bit addressable.
// - Two 512 byte register areas at 00'FE00 and 00'F000 decode.
// - Flash is a 32 Kbyte and a 132 Kbyte module in 4 Kbyte sectors.
// - Sector C0'F000 to C0'FFFF is reserved for control and protection data.
// - Per sector write protection except sector 40, and erase; programming in 128 byte blocks.
// - Flash read protection unlocks only after the password sequence.
// - Flash reads deliver 128 bits and are error corrected when ECC mode is selected.
// - Accesses to the two flash modules proceed in parallel.
// - With parity on, single bit errors are detected and data discarded.
// - With ECC on, single bit errors are corrected before returning data.
`timescale 1ns/1ps
module umd_decoder
  import umd_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Static configuration from the system.
  input  wire logic              ext_bus_present,
  input  wire logic              pram_wp_en,
  input  wire logic [11:0]       pram_wp_size,
  input  wire logic [39:0]       fl_sect_wp,
  input  wire logic              fl_read_prot,
  input  wire logic              fl_unlocked,
  input  wire umd_prot_mode_t    mem_prot_mode,
  // Code fetch port.
  input  wire umd_req_t          fetch_req,
  // Data transfer port.
  input  wire umd_req_t          data_req,
  // Memory read data check on the returning path.
  input  wire logic [15:0]       rd_data,
  input  wire logic              rd_parity,
  input  wire logic [4:0]        rd_syndrome,
  // Routed code fetch.
  output umd_route_t             fetch_route_q,
  // Routed data transfer.
  output umd_route_t             data_route_q,
  // Checked read data.
  output logic [15:0]            rd_data_q,
  output logic                   rd_err_q,
  output logic                   rd_corr_q
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Decode is a pure function so both ports share one set of bounds.
  function automatic umd_route_t decode(input umd_req_t r, input logic is_fetch);
    umd_route_t  o;
    logic [23:0] a;
    logic [5:0]  sect;
    logic        sect_wp;
    a = r.addr;
    o = '0;
    o.valid = r.valid;
    o.page  = a[PAGE_LSB +: PAGE_W];
    o.addr  = a;
    sect    = 6'h00;
    sect_wp = 1'b0;
    if (a >= IMB_LO) begin
      o.target = UMD_T_IMB;
    end else if (a >= EPRAM_LO && a <= EPRAM_HI) begin
      o.target = UMD_T_EPRAM;
      o.addr   = {EPRAM_LO[23:12], a[11:0]};
    end else if (a >= PRAM_LO && a <= PRAM_HI) begin
      o.target = UMD_T_PRAM;
      o.addr   = {PRAM_LO[23:12], a[11:0]};
      o.wr_block = r.write && pram_wp_en && (a[11:0] < pram_wp_size);
    end else if (a >= FL1_LO && a <= FL1_HI) begin
      o.target = UMD_T_FLASH1;
      sect = 6'd33 + {3'b000, a[14:12]};
    end else if (a >= FL0_LO && a <= FL0_HI) begin
      o.target = UMD_T_FLASH0;
      sect = a[17:12];
      o.fl_ctl = (a >= FL0_CTL_LO && a <= FL0_CTL_HI);
    end else if ((a >= CAN_LO && a <= SCU_HI) || (a >= CANA_LO && a <= SCUA_HI)) begin
      o.target = UMD_T_LPBUS;
    end else if (a[23:16] == SYS_SEG) begin
      if (a >= SFR_LO) begin
        o.target   = UMD_T_SFR;
        o.bit_addr = 1'b1;
      end else if (a >= DPR_LO && a <= DPR_HI) begin
        o.target   = UMD_T_DUAL_PORT_RAM;
        o.bit_addr = (a >= DPR_BIT_LO);
      end else if (a >= EXTENDED_FUNCTION_REGS_LO && a <= EXTENDED_FUNCTION_REGS_HI) begin
        o.target   = UMD_T_EXTENDED_FUNCTION_REGS;
        o.bit_addr = 1'b1;
      end else if (a >= EXTRA_FUNCTION_REGS_LO && a <= EXTRA_FUNCTION_REGS_HI) begin
        o.target = UMD_T_EXTRA_FUNCTION_REGS;
      end else if (a >= DRAM_LO && a <= DRAM_HI) begin
        o.target = UMD_T_DRAM;
      end else begin
        o.target = ext_bus_present ? UMD_T_EXT : UMD_T_NONE;
      end
    end else begin
      o.target = ext_bus_present ? UMD_T_EXT : UMD_T_NONE;
    end
    // Flash write protection per sector; read protection covers all flash sectors.
    // The top flash1 sector has no protect bit, so it is never write blocked by sector.
    if (o.target == UMD_T_FLASH0 || o.target == UMD_T_FLASH1) begin
      sect_wp = (sect < 6'd40) ? fl_sect_wp[sect] : 1'b0;
      if (r.write && (sect_wp || o.fl_ctl)) begin
        o.wr_block = 1'b1;
      end
      if (fl_read_prot && !fl_unlocked) begin
        o.wr_block = 1'b1;
      end
    end
    // Fetch port: fetch-side targets local, others over the system bus; data port: fetch-side, LPBUS and EXT targets over it.
    if (is_fetch) begin
      o.via_sysbus = !(o.target inside {UMD_T_FLASH0, UMD_T_FLASH1,
                                        UMD_T_PRAM, UMD_T_EPRAM});
    end else begin
      o.via_sysbus = (o.target inside {UMD_T_FLASH0, UMD_T_FLASH1, UMD_T_PRAM,
                                       UMD_T_EPRAM, UMD_T_LPBUS, UMD_T_EXT});
    end
    if (!r.valid) begin
      o.target = UMD_T_NONE;
    end
    return o;
  endfunction

  // ----------------------------------------------------------------------
  // Routing registers
  // ----------------------------------------------------------------------

  // Both ports decode every cycle, so flash0 and flash1 traffic never serialises.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fetch_route_q <= '0;
    end else begin
      fetch_route_q <= decode(fetch_req, 1'b1);
    end
  end

  // The data port has its own register, so it runs beside the fetch port.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_route_q <= '0;
    end else begin
      data_route_q <= decode(data_req, 1'b0);
    end
  end

  // ----------------------------------------------------------------------
  // Soft error check
  // ----------------------------------------------------------------------

  // A syndrome naming bit k flips it; a parity hit only flags, the data is dropped.
  logic [15:0] corr_d;
  logic        par_bad;
  assign par_bad = (^rd_data) != rd_parity;

  always_comb begin
    corr_d = rd_data;
    if (rd_syndrome != 5'h00 && rd_syndrome <= 5'd16) begin
      corr_d[rd_syndrome[3:0] - 4'h1] = ~rd_data[rd_syndrome[3:0] - 4'h1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data_q <= 16'h0000;
      rd_err_q  <= 1'b0;
      rd_corr_q <= 1'b0;
    end else begin
      case (mem_prot_mode)
        UMD_PROT_PARITY: begin
          rd_data_q <= par_bad ? 16'h0000 : rd_data;
          rd_err_q  <= par_bad;
          rd_corr_q <= 1'b0;
        end
        UMD_PROT_ECC: begin
          rd_data_q <= corr_d;
          rd_err_q  <= rd_syndrome > 5'd16;
          rd_corr_q <= rd_syndrome != 5'h00 && rd_syndrome <= 5'd16;
        end
        default: begin
          rd_data_q <= rd_data;
          rd_err_q  <= 1'b0;
          rd_corr_q <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** tb/umd_cpu_model.sv ***
// Model of the CPU fetch and data pipeline units that issue requests to the decoder.
`timescale 1ns/1ps
module umd_cpu_model
  import umd_pkg::*;
(
  // Clock and reset.
  input  wire logic     clk_sys,
  input  wire logic     srst,
  // Commands from the bench.
  input  wire umd_req_t cmd_f,
  input  wire umd_req_t cmd_d,
  // Requests towards the decoder.
  output umd_req_t      fetch_req,
  output umd_req_t      data_req
);
  logic [23:0] last_f_q;
  logic [23:0] last_d_q;

  // Remember the last address so that an idle port can show its inverse, not a stale value.
  always_ff @(posedge clk_sys) begin
    if (cmd_f.valid) last_f_q <= cmd_f.addr;
    if (cmd_d.valid) last_d_q <= cmd_d.addr;
  end

  // An idle pipeline does not hold its address, so a decoder must not rely on it.
  always_comb begin
    fetch_req = cmd_f;
    data_req  = cmd_d;
    if (!cmd_f.valid) fetch_req.addr = ~last_f_q;
    if (!cmd_d.valid) data_req.addr = ~last_d_q;
  end
endmodule

// *** tb/umd_decoder_asserts.sv ***
// Checker of the decoder's routing and read data checks.
`timescale 1ns/1ps
module umd_decoder_asserts
  import umd_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic           clk_sys,
  input wire logic           srst,
  input wire logic           ext_bus_present,
  input wire umd_prot_mode_t mem_prot_mode,
  input wire umd_req_t       fetch_req,
  input wire umd_req_t       data_req,
  input wire logic [15:0]    rd_data,
  input wire logic           rd_parity,
  input wire logic [4:0]     rd_syndrome,
  // Outputs.
  input wire umd_route_t     fetch_route_q,
  input wire umd_route_t     data_route_q,
  input wire logic [15:0]    rd_data_q,
  input wire logic           rd_err_q,
  input wire logic           rd_corr_q
);
  logic [15:0] fix_w;

  // Corrected word for a single bit syndrome; only meaningful for syndromes 1 to 16.
  always_comb fix_w = rd_data ^ (16'h0001 << (rd_syndrome - 5'h01));

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_pram_fetch;
    fetch_req.valid && fetch_req.addr >= PRAM_LO && fetch_req.addr <= PRAM_HI;
  endsequence
  sequence s_epram_fetch;
    fetch_req.valid && fetch_req.addr >= EPRAM_LO && fetch_req.addr <= EPRAM_HI;
  endsequence

  a_pram_alias: assert property (
    s_pram_fetch |=> fetch_route_q.target == UMD_T_PRAM &&
    fetch_route_q.addr == {12'hE00, $past(fetch_req.addr[11:0])}) else $error("pram alias");
  a_epram_alias: assert property (
    s_epram_fetch |=> fetch_route_q.target == UMD_T_EPRAM &&
    fetch_route_q.addr == {12'hE80, $past(fetch_req.addr[11:0])}) else $error("epram alias");
  a_dram_local: assert property (
    data_req.valid && data_req.addr >= DRAM_LO && data_req.addr <= DRAM_HI
    |=> data_route_q.target == UMD_T_DRAM && !data_route_q.via_sysbus) else $error("dram");
  a_lpbus_fwd: assert property (
    data_req.valid && data_req.addr >= CAN_LO && data_req.addr <= SCU_HI
    |=> data_route_q.target == UMD_T_LPBUS && data_route_q.via_sysbus) else $error("lpbus");
  a_resv_ext: assert property (
    ext_bus_present && data_req.valid && data_req.addr >= 24'h205000 &&
    data_req.addr <= 24'h207FFF |=> data_route_q.target == UMD_T_EXT) else $error("ext");
  a_idle_none: assert property (
    !data_req.valid |=> data_route_q.target == UMD_T_NONE) else $error("idle target");
  a_ctl_block: assert property (
    data_req.valid && data_req.write && data_req.addr >= FL0_CTL_LO &&
    data_req.addr <= FL0_CTL_HI |=> data_route_q.wr_block) else $error("ctl block");
  a_parity_drop: assert property (
    mem_prot_mode == UMD_PROT_PARITY && (^rd_data != rd_parity)
    |=> rd_err_q && rd_data_q == 16'h0000) else $error("parity");
  a_ecc_fix: assert property (
    mem_prot_mode == UMD_PROT_ECC && rd_syndrome != 5'h00 && rd_syndrome <= 5'h10
    |=> rd_corr_q && !rd_err_q && rd_data_q == $past(fix_w)) else $error("ecc");
  a_page_field: assert property (
    data_req.valid |=> data_route_q.page == $past(data_req.addr[15:14])) else $error("page");
endmodule
bind umd_decoder umd_decoder_asserts u_umd_decoder_asserts (.clk_sys, .srst, .ext_bus_present,
  .mem_prot_mode, .fetch_req, .data_req, .rd_data, .rd_parity, .rd_syndrome, .fetch_route_q,
  .data_route_q, .rd_data_q, .rd_err_q, .rd_corr_q);

// *** tb/tb_top.sv ***
// Self-checking testbench for the memory map decoder.
`timescale 1ns/1ps
module tb_top
  import umd_pkg::*;
;
  logic clk_sys = 1'b0, srst = 1'b1, ext_bus_present, pram_wp_en, fl_read_prot, fl_unlocked;
  logic rd_parity, rd_err_q, rd_corr_q, bad, fix;
  logic [11:0] pram_wp_size;
  logic [39:0] fl_sect_wp;
  logic [15:0] rd_data, rd_data_q;
  logic [4:0] rd_syndrome;
  logic [31:0] r, r2;
  umd_prot_mode_t mem_prot_mode;
  umd_req_t cmd_f, cmd_d, fetch_req, data_req;
  umd_route_t fetch_route_q, data_route_q;
  umd_target_t t, tf;
  int err_total = 0, checked = 0, cyc = 0;
  integer seed = 32'h7929BC66;
  localparam logic [23:0] CORNER [16] = '{24'hE01234, 24'hE7FFFF, 24'hE81000, 24'hC0F000,
    24'hC20FFF, 24'hC21000, 24'hC47FFF, 24'h204FFF, 24'h205000, 24'h20B7FF, 24'h00FE00,
    24'h00FDFF, 24'h00F1FF, 24'h00C800, 24'h00C7FF, 24'hFFFF00};

  umd_decoder u_umd_decoder (.clk_sys, .srst, .ext_bus_present, .pram_wp_en, .pram_wp_size,
    .fl_sect_wp, .fl_read_prot, .fl_unlocked, .mem_prot_mode, .fetch_req, .data_req, .rd_data,
    .rd_parity, .rd_syndrome, .fetch_route_q, .data_route_q, .rd_data_q, .rd_err_q, .rd_corr_q);
  umd_cpu_model u_umd_cpu_model (.clk_sys, .srst, .cmd_f, .cmd_d, .fetch_req, .data_req);

  // Clock and a cycle ceiling well above the 411 cycles the run needs.
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic inr(input logic [23:0] a, lo, hi);
    return a >= lo && a <= hi;
  endfunction
  // Reference decode; anything not mapped on chip is a reserved or external area.
  function automatic umd_target_t exp_tgt(input logic [23:0] a, input logic ext);
    if (a >= IMB_LO) return UMD_T_IMB;
    if (inr(a, EPRAM_LO, EPRAM_HI)) return UMD_T_EPRAM;
    if (inr(a, PRAM_LO, PRAM_HI)) return UMD_T_PRAM;
    if (inr(a, FL1_LO, FL1_HI)) return UMD_T_FLASH1;
    if (inr(a, FL0_LO, FL0_HI)) return UMD_T_FLASH0;
    if (inr(a, CAN_LO, SCU_HI) || inr(a, CANA_LO, SCUA_HI)) return UMD_T_LPBUS;
    if (inr(a, SFR_LO, SFR_HI)) return UMD_T_SFR;
    if (inr(a, DPR_LO, DPR_HI)) return UMD_T_DUAL_PORT_RAM;
    if (inr(a, EXTENDED_FUNCTION_REGS_LO, EXTENDED_FUNCTION_REGS_HI)) return UMD_T_EXTENDED_FUNCTION_REGS;
    if (inr(a, EXTRA_FUNCTION_REGS_LO, EXTRA_FUNCTION_REGS_HI)) return UMD_T_EXTRA_FUNCTION_REGS;
    if (inr(a, DRAM_LO, DRAM_HI)) return UMD_T_DRAM;
    return ext ? UMD_T_EXT : UMD_T_NONE;
  endfunction
  // Expected block flag of a flash access; sector 40 carries no protect bit.
  function automatic logic exp_blk(input logic [23:0] a, input logic w);
    logic [5:0] s;
    s = inr(a, FL1_LO, FL1_HI) ? 6'd33 + 6'(a[14:12]) : a[17:12];
    return (w && ((s < 6'd40 && fl_sect_wp[s]) || inr(a, FL0_CTL_LO, FL0_CTL_HI))) ||
           (fl_read_prot && !fl_unlocked);
  endfunction
  function automatic logic [23:0] exp_addr(input logic [23:0] a);
    if (inr(a, PRAM_LO, PRAM_HI)) return {12'hE00, a[11:0]};
    if (inr(a, EPRAM_LO, EPRAM_HI)) return {12'hE80, a[11:0]};
    return a;
  endfunction

  task automatic chk(input logic [23:0] s, e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Each cycle checks the answer to the inputs still held, then drives the next request.
  initial begin
    {ext_bus_present, pram_wp_en, fl_read_prot, fl_unlocked, rd_parity} = 5'h00;
    {pram_wp_size, fl_sect_wp, rd_data, rd_syndrome, cmd_f, cmd_d} = '0;
    mem_prot_mode = UMD_PROT_OFF;
    repeat (10) @(posedge clk_sys);
    #1 srst = 1'b0;
    for (int i = 0; i <= 400; i++) begin
      @(posedge clk_sys);
      #1;
      if (i > 0) begin
        t = exp_tgt(cmd_d.addr, ext_bus_present);
        tf = exp_tgt(cmd_f.addr, ext_bus_present);
        chk(24'(data_route_q.target), 24'(cmd_d.valid ? t : UMD_T_NONE));
        if (tf inside {UMD_T_FLASH0, UMD_T_FLASH1, UMD_T_PRAM, UMD_T_EPRAM}) begin
          chk(24'(fetch_route_q.target), 24'(tf));
          chk(24'(fetch_route_q.via_sysbus), 24'h000000);
        end
        if (cmd_d.valid) begin
          chk(data_route_q.addr, exp_addr(cmd_d.addr));
          chk(24'(data_route_q.page), 24'(cmd_d.addr[15:14]));
          chk(24'(data_route_q.fl_ctl), 24'(inr(cmd_d.addr, FL0_CTL_LO, FL0_CTL_HI)));
          chk(24'(data_route_q.bit_addr), 24'(t inside {UMD_T_SFR, UMD_T_EXTENDED_FUNCTION_REGS} ||
              (t == UMD_T_DUAL_PORT_RAM && cmd_d.addr >= DPR_BIT_LO)));
          if (t inside {UMD_T_FLASH0, UMD_T_FLASH1})
            chk(24'(data_route_q.wr_block), 24'(exp_blk(cmd_d.addr, cmd_d.write)));
          if (t inside {UMD_T_LPBUS, UMD_T_DRAM})
            chk(24'(data_route_q.via_sysbus), 24'(t == UMD_T_LPBUS));
          if (cmd_d.write && t == UMD_T_PRAM && pram_wp_en)
            chk(24'(data_route_q.wr_block), 24'(cmd_d.addr[11:0] < pram_wp_size));
        end
        bad = (mem_prot_mode == UMD_PROT_PARITY) ? (^rd_data != rd_parity) :
              (mem_prot_mode == UMD_PROT_ECC && rd_syndrome > 5'h10);
        fix = mem_prot_mode == UMD_PROT_ECC && rd_syndrome != 5'h00 && !bad;
        chk(24'(rd_err_q), 24'(bad));
        chk(24'(rd_corr_q), 24'(fix));
        if (!(bad && mem_prot_mode == UMD_PROT_ECC))
          chk(24'(rd_data_q), 24'(fix ? rd_data ^ (16'h0001 << (rd_syndrome - 5'h01)) :
              (bad ? 16'h0000 : rd_data)));
      end
      r = $random(seed);
      r2 = $random(seed);
      cmd_d.addr = (i < 16) ? CORNER[i] : {CORNER[r[3:0]][23:12], r[15:4]};
      cmd_f.addr = (i < 16) ? CORNER[15 - i] : {CORNER[r2[3:0]][23:12], r2[15:4]};
      cmd_d.valid = r[16] | (i < 16);
      cmd_f.valid = 1'b1;
      // Software never writes the register areas, keeping unused addresses untouched.
      cmd_d.write = r[17] & ~inr(cmd_d.addr, SFR_LO, SFR_HI) & ~inr(cmd_d.addr, EXTENDED_FUNCTION_REGS_LO, EXTENDED_FUNCTION_REGS_HI);
      {cmd_f.write, cmd_d.word, cmd_f.word} = {1'b0, r[18], r2[18]};
      {ext_bus_present, pram_wp_en, fl_read_prot, fl_unlocked, rd_parity} = r[23:19];
      {pram_wp_size, rd_data} = {r2[27:16], r2[31:16]};
      fl_sect_wp = {r, r2[7:0]};
      rd_syndrome = r[28:24];
      mem_prot_mode = umd_prot_mode_t'(i % 3);
    end
    tally_and_finish();
  end
endmodule
